// ==== csl_clock_ctrl.sv ====
// halt control, sticky lock-loss flags and divider phase settings
// assumes a synchronous byte register port and level lock indications
`include "csl_consts.svh"

module csl_clock_ctrl
  import csl_pkg::*;
#(
  parameter int NUM_SYNTH = `CSL_NUM_SYNTH,
  parameter int NUM_HP_OUT = `CSL_NUM_HP_OUT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rd_data,
  // divider sources: s0 c, s0 d, s1 c, s1 d
  input wire logic [NUM_HP_OUT-1:0] div_src_clk,
  // synthesizer lock indications, high while locked
  input wire logic [NUM_SYNTH-1:0] synth_locked,
  // high-performance outputs
  output logic hp_output_zero,
  output logic hp_output_one,
  output logic hp_output_two,
  output logic hp_output_three,
  output logic [NUM_HP_OUT-1:0] hp_output_parked,
  // lock-loss flags
  output logic [NUM_SYNTH-1:0] s_lock_lost,
  // phase settings for synthesizer 0 divider c
  output logic [`CSL_PERIOD_W-1:0] s0_divc_period_shift,
  output logic [`CSL_PERIOD_W-1:0] s0_divc_delay_periods,
  output logic [`CSL_PERIOD_W-1:0] s0_divc_advance_periods,
  output logic [`CSL_QUAD_W-1:0] s0_divc_quadrature_sel,
  output logic [3:0] s0_divc_quad_steps,
  output logic s0_divc_phase_update
);

  // ==========================================================================
  // register write decode
  logic [7:0] halt_ctrl_ff;
  logic [7:0] lock_clear_ff;
  logic [15:0] phase_ff;
  logic [NUM_SYNTH-1:0] lock_flag_ff;
  logic [7:0] rd_data_ff;
  logic update_ff;
  wire wr_halt = reg_wr && (reg_addr == `CSL_ADDR_HALT_CTRL);
  wire wr_clear = reg_wr && (reg_addr == `CSL_ADDR_LOCK_CLEAR);
  wire wr_ph_lo = reg_wr && (reg_addr == `CSL_ADDR_PHASE_LO);
  wire wr_ph_hi = reg_wr && (reg_addr == `CSL_ADDR_PHASE_HI);

  // control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halt_ctrl_ff <= `CSL_RST_HALT_CTRL;
      lock_clear_ff <= `CSL_RST_LOCK_CLEAR;
    end else begin
      if (wr_halt) halt_ctrl_ff <= reg_wdata;
      if (wr_clear) lock_clear_ff <= reg_wdata;
    end
  end

  // phase register, low byte first address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= `CSL_RST_PHASE;
      update_ff <= 1'b0;
    end else begin
      if (wr_ph_lo) phase_ff[7:0] <= reg_wdata;
      if (wr_ph_hi) phase_ff[15:8] <= reg_wdata;
      update_ff <= wr_ph_lo || wr_ph_hi;
    end
  end

  // ==========================================================================
  // output halt cells, one per high-performance output
  logic [NUM_HP_OUT-1:0] hp_out;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_HP_OUT; gi++) begin : g_halt
      csl_halt_cell u_cell (
        .clk(clk),
        .reset_n(reset_n),
        .halt_code(halt_ctrl_ff[gi*2 +: 2]),
        .src_clk(div_src_clk[gi]),
        .out_clk(hp_out[gi]),
        .parked(hp_output_parked[gi])
      );
    end
  endgenerate

  assign hp_output_zero = hp_out[0];
  assign hp_output_one = hp_out[1];
  assign hp_output_two = hp_out[2];
  assign hp_output_three = hp_out[3];

  // ==========================================================================
  // sticky lock-loss flags: a loss in a clear cycle still sets
  wire [NUM_SYNTH-1:0] lock_loss = ~synth_locked;
  wire [NUM_SYNTH-1:0] clear_hit = lock_clear_ff[NUM_SYNTH-1:0];
  wire [NUM_SYNTH-1:0] nxt_lock_flag =
    lock_loss | (lock_flag_ff & ~clear_hit);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_flag_ff <= `CSL_RST_LOCK_FLAGS;
    end else begin
      lock_flag_ff <= nxt_lock_flag;
    end
  end

  assign s_lock_lost = lock_flag_ff;

  // ==========================================================================
  // phase field decode
  wire [`CSL_PERIOD_W-1:0] period_cnt = phase_ff[`CSL_PERIOD_MSB:0];
  wire period_neg = period_cnt[`CSL_PERIOD_MSB];
  wire [`CSL_PERIOD_W-1:0] period_mag = period_neg ?
    (`CSL_PERIOD_W'(~period_cnt + `CSL_PERIOD_W'(1))) : period_cnt;
  wire [`CSL_QUAD_W-1:0] quad_code =
    phase_ff[`CSL_QUAD_LSB +: `CSL_QUAD_W];
  logic [3:0] quad_steps;

  // quadrature code to signed 45-degree steps
  always_comb begin
    case (quad_code)
      `CSL_QC_0: quad_steps = `CSL_QS_0;
      `CSL_QC_M45: quad_steps = `CSL_QS_M45;
      `CSL_QC_M90: quad_steps = `CSL_QS_M90;
      `CSL_QC_P135: quad_steps = `CSL_QS_P135;
      `CSL_QC_180: quad_steps = `CSL_QS_180;
      `CSL_QC_M135: quad_steps = `CSL_QS_M135;
      `CSL_QC_P90: quad_steps = `CSL_QS_P90;
      `CSL_QC_P45: quad_steps = `CSL_QS_P45;
      default: quad_steps = `CSL_QS_0;
    endcase
  end

  // registered phase outputs
  logic [`CSL_PERIOD_W-1:0] delay_ff, advance_ff;
  logic [3:0] steps_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      delay_ff <= '0;
      advance_ff <= '0;
      steps_ff <= `CSL_QS_0;
    end else begin
      delay_ff <= period_neg ? period_mag : '0;
      advance_ff <= period_neg ? '0 : period_mag;
      steps_ff <= quad_steps;
    end
  end

  assign s0_divc_period_shift = period_cnt;
  assign s0_divc_delay_periods = delay_ff;
  assign s0_divc_advance_periods = advance_ff;
  assign s0_divc_quadrature_sel = quad_code;
  assign s0_divc_quad_steps = steps_ff;
  assign s0_divc_phase_update = update_ff;

  // ==========================================================================
  // read-back mux, unmapped addresses and unused lock status bits read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `CSL_ADDR_HALT_CTRL: rd_mux = halt_ctrl_ff;
      `CSL_ADDR_LOCK_STATUS: rd_mux = 8'(lock_flag_ff);
      `CSL_ADDR_LOCK_CLEAR: rd_mux = lock_clear_ff;
      `CSL_ADDR_PHASE_LO: rd_mux = phase_ff[7:0];
      `CSL_ADDR_PHASE_HI: rd_mux = phase_ff[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= rd_mux;
    end
  end

  assign reg_rd_data = rd_data_ff;

endmodule // csl_clock_ctrl

// ==== csl_consts.svh ====
// constants for the clock halt, lock-loss flag and phase control block
// assumes a byte-wide register port clocked by clk at 25 MHz
// ==========================================================================
`ifndef CSL_CONSTS_SVH
`define CSL_CONSTS_SVH

// ==========================================================================
// register byte addresses
`define CSL_ADDR_HALT_CTRL 8'hb8
`define CSL_ADDR_LOCK_STATUS 8'hb9
`define CSL_ADDR_LOCK_CLEAR 8'hba
`define CSL_ADDR_PHASE_LO 8'hbf
`define CSL_ADDR_PHASE_HI 8'hc0

// ==========================================================================
// reset values
`define CSL_RST_HALT_CTRL 8'h00
`define CSL_RST_LOCK_CLEAR 8'h00
`define CSL_RST_PHASE 16'h0000
`define CSL_RST_LOCK_FLAGS 4'hf

// ==========================================================================
// field layout
`define CSL_HALT_FIELD_W 2
`define CSL_HALT_ON_BIT 1
`define CSL_HALT_LEVEL_BIT 0
`define CSL_PERIOD_MSB 12
`define CSL_PERIOD_W 13
`define CSL_QUAD_LSB 13
`define CSL_QUAD_W 3
`define CSL_NUM_SYNTH 4
`define CSL_NUM_HP_OUT 4

// ==========================================================================
// quadrature codes and their signed 45-degree step counts
`define CSL_QC_0 3'h0
`define CSL_QC_M45 3'h1
`define CSL_QC_M90 3'h2
`define CSL_QC_P135 3'h3
`define CSL_QC_180 3'h4
`define CSL_QC_M135 3'h5
`define CSL_QC_P90 3'h6
`define CSL_QC_P45 3'h7
`define CSL_QS_0 4'h0
`define CSL_QS_M45 4'hf
`define CSL_QS_M90 4'he
`define CSL_QS_M135 4'hd
`define CSL_QS_180 4'h4
`define CSL_QS_P135 4'h3
`define CSL_QS_P90 4'h2
`define CSL_QS_P45 4'h1

`endif

// ==== csl_pkg.sv ====
// types for the clock halt, lock-loss flag and phase control block
// assumes nothing beyond the constants header
package csl_pkg;

  // ==========================================================================
  // halt cell states
  typedef enum logic [1:0] {
    CSL_RUN,
    CSL_SEEK_EDGE,
    CSL_PARKED,
    CSL_SEEK_RESUME
  } csl_halt_state_t;

endpackage

// ==== csl_halt_cell.sv ====
// one output halt cell: passes a divider clock or parks it at a level
// assumes the divider level is synchronous to clk
`include "csl_consts.svh"

module csl_halt_cell
  import csl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control field and source
  input wire logic [1:0] halt_code,
  input wire logic src_clk,
  // gated output
  output logic out_clk,
  output logic parked
);

  // ==========================================================================
  // decode
  csl_halt_state_t state_ff, nxt_state;
  logic out_ff, nxt_out;
  wire halt_on = halt_code[`CSL_HALT_ON_BIT];
  wire park_level = halt_code[`CSL_HALT_LEVEL_BIT];
  wire at_level = (src_clk == park_level);

  // edge-aligned halt and glitch-free resume
  always_comb begin
    nxt_state = state_ff;
    nxt_out = src_clk;
    case (state_ff)
      CSL_RUN: begin
        if (halt_on) begin
          nxt_state = CSL_SEEK_EDGE;
        end
      end
      CSL_SEEK_EDGE: begin
        if (!halt_on) begin
          nxt_state = CSL_RUN;
        end else if (at_level) begin
          nxt_state = CSL_PARKED;
          nxt_out = park_level;
        end
      end
      CSL_PARKED: begin
        nxt_out = out_ff; // hold parked level
        if (!halt_on) begin
          nxt_state = CSL_SEEK_RESUME;
        end else if (park_level != out_ff) begin
          nxt_state = CSL_SEEK_EDGE; // level code changed while parked
          nxt_out = src_clk;
        end
      end
      CSL_SEEK_RESUME: begin
        nxt_out = out_ff;
        if (halt_on) begin
          nxt_state = CSL_PARKED;
        end else if (src_clk == out_ff) begin
          nxt_state = CSL_RUN; // rejoin without a runt pulse
          nxt_out = src_clk;
        end
      end
      default: begin
        nxt_state = CSL_RUN;
      end
    endcase
  end

  // state and output flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= CSL_RUN;
      out_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      out_ff <= nxt_out;
    end
  end

  assign out_clk = out_ff;
  assign parked = (state_ff == CSL_PARKED);

endmodule // csl_halt_cell

// ==== csl_clock_ctrl_asserts.sv ====
// checker for the halt, lock-loss flag and phase ports of csl_clock_ctrl
// assumes one clock domain and the register port timing of the block
module csl_clock_ctrl_asserts
  import csl_pkg::*;
#(
  parameter int NUM_SYNTH = 4,
  parameter int NUM_HP_OUT = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // sources and lock
  input wire logic [NUM_HP_OUT-1:0] div_src_clk,
  input wire logic [NUM_SYNTH-1:0] synth_locked,
  // outputs watched
  input wire logic hp_output_zero,
  input wire logic [NUM_HP_OUT-1:0] hp_output_parked,
  input wire logic [NUM_SYNTH-1:0] s_lock_lost,
  input wire logic [12:0] s0_divc_period_shift,
  input wire logic [12:0] s0_divc_delay_periods,
  input wire logic [12:0] s0_divc_advance_periods,
  input wire logic s0_divc_phase_update
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [NUM_SYNTH-1:0] clr_ff;
  logic seek_ff;

  // ====================
  // shadow of the clear register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) clr_ff <= '0;
    else if (reg_wr && reg_addr == 8'hba) clr_ff <= reg_wdata[NUM_SYNTH-1:0];
  end

  // output zero resuming: held until the source meets the parked level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) seek_ff <= 1'b0;
    else seek_ff <= hp_output_parked[0] ||
      (seek_ff && (div_src_clk[0] != hp_output_zero));
  end

  // ====================
  // lock flags
  property p_lock_set;
    !(&synth_locked) |=> &(s_lock_lost | $past(synth_locked));
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("flag not set");
  property p_lock_reset;
    disable iff (1'b0) !reset_n |-> &s_lock_lost;
  endproperty
  a_lock_reset: assert property (p_lock_reset) else $error("flag reset");
  property p_lock_clear;
    |(clr_ff & synth_locked) |=>
      (s_lock_lost & $past(clr_ff) & $past(synth_locked)) == '0;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("no clear");
  property p_lock_hold;
    &synth_locked |=> (s_lock_lost & ~$past(s_lock_lost)) == '0;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("false set");

  // ====================
  // halt and phase
  property p_follow;
    !hp_output_parked[0] && !seek_ff && $past(reset_n) |->
      hp_output_zero == $past(div_src_clk[0]);
  endproperty
  a_follow: assert property (p_follow) else $error("out not src");
  property p_park_still;
    hp_output_parked[0] && $past(hp_output_parked[0]) |->
      $stable(hp_output_zero);
  endproperty
  a_park_still: assert property (p_park_still) else $error("runt");
  property p_phase_pulse;
    reg_wr && (reg_addr == 8'hbf || reg_addr == 8'hc0) |=> s0_divc_phase_update;
  endproperty
  a_phase_pulse: assert property (p_phase_pulse) else $error("no upd");
  property p_delay_neg;
    s0_divc_period_shift[12] |=> s0_divc_advance_periods == '0 &&
      (s0_divc_delay_periods + $past(s0_divc_period_shift)) == '0;
  endproperty
  a_delay_neg: assert property (p_delay_neg) else $error("bad delay");
endmodule // csl_clock_ctrl_asserts

bind csl_clock_ctrl csl_clock_ctrl_asserts #(
  .NUM_SYNTH(NUM_SYNTH), .NUM_HP_OUT(NUM_HP_OUT)
) u_csl_clock_ctrl_asserts (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .div_src_clk(div_src_clk),
  .synth_locked(synth_locked), .hp_output_zero(hp_output_zero),
  .hp_output_parked(hp_output_parked), .s_lock_lost(s_lock_lost),
  .s0_divc_period_shift(s0_divc_period_shift),
  .s0_divc_delay_periods(s0_divc_delay_periods),
  .s0_divc_advance_periods(s0_divc_advance_periods),
  .s0_divc_phase_update(s0_divc_phase_update)
);

// ==== csl_host_model.sv ====
// host side of the byte register port
// assumes the block registers reads one cycle after the address
module csl_host_model
  import csl_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  input wire logic [7:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // ====================
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
  end

  // one write pulse, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // read: data seen one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    @(posedge clk);
    #1 d = reg_rd_data;
  endtask

  // clear flags, then drop the clear bits again
  task automatic clr(input logic [3:0] m);
    wr(8'hba, {4'h0, m});
    wr(8'hba, 8'h00);
  endtask
endmodule // csl_host_model

// ==== csl_clock_ctrl_bench.sv ====
// directed register-level tests of csl_clock_ctrl
// assumes the host model drives the register port
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  failures++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module csl_clock_ctrl_bench
  import csl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic reset_n;
  logic [3:0] div_cnt = 4'h0;
  logic [3:0] synth_locked;
  logic [7:0] rdata;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic [7:0] reg_rd_data;
  logic [3:0] hp_outs;
  logic [3:0] parked;
  logic [3:0] lost;
  logic [12:0] shift;
  logic [12:0] dly;
  logic [12:0] adv;
  logic [2:0] qsel;
  logic [3:0] qstep;
  int failures;
  int n_checks;
  logic [3:0] qs [8] = '{4'h0, 4'hf, 4'he, 4'h3, 4'h4, 4'hd, 4'h2, 4'h1};

  // ====================
  // design and host
  csl_clock_ctrl u_csl_clock_ctrl (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd_data(reg_rd_data),
    .div_src_clk({div_cnt[0], div_cnt[3], div_cnt[1], div_cnt[2]}),
    .synth_locked(synth_locked), .hp_output_zero(hp_outs[0]),
    .hp_output_one(hp_outs[1]), .hp_output_two(hp_outs[2]),
    .hp_output_three(hp_outs[3]), .hp_output_parked(parked),
    .s_lock_lost(lost), .s0_divc_period_shift(shift),
    .s0_divc_delay_periods(dly), .s0_divc_advance_periods(adv),
    .s0_divc_quadrature_sel(qsel), .s0_divc_quad_steps(qstep),
    .s0_divc_phase_update()
  );
  csl_host_model u_csl_host_model (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd_data(reg_rd_data)
  );

  // clock and divider levels
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) div_cnt <= #1 div_cnt + 4'h1;

  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end

  // ====================
  // tests
  initial begin
    reset_n = 1'b1;
    synth_locked = 4'hf;
    failures = 0;
    n_checks = 0;
    #1 reset_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    `CHK("flags", 4'hf, lost)
    u_csl_host_model.wr(8'hb9, 8'h00);
    u_csl_host_model.rd(8'hb9, rdata);
    `CHK("status", 8'h0f, rdata)
    u_csl_host_model.rd(8'hbb, rdata);
    `CHK("unmapped", 8'h00, rdata)
    u_csl_host_model.clr(4'h5);
    u_csl_host_model.rd(8'hb9, rdata);
    `CHK("cleared", 8'h0a, rdata)
    u_csl_host_model.clr(4'ha);
    synth_locked = 4'hb;
    @(posedge clk);
    #1 synth_locked = 4'hf;
    repeat (4) @(posedge clk);
    #1 `CHK("lost", 4'h4, lost)
    u_csl_host_model.clr(4'h4);
    `CHK("relock", 4'h0, lost)
    for (int i = 0; i < 4; i++) begin
      for (int c = 2; c < 4; c++) begin
        u_csl_host_model.wr(8'hb8, 8'(c << (2 * i)));
        repeat (20) @(posedge clk);
        #1 `CHK("parked", 4'(1 << i), parked)
        `CHK("level", c[0], hp_outs[i])
        u_csl_host_model.wr(8'hb8, 8'(1 << (2 * i)));
        repeat (20) @(posedge clk);
        #1 `CHK("run", 4'h0, parked)
      end
    end
    u_csl_host_model.wr(8'hbf, 8'hff);
    u_csl_host_model.wr(8'hc0, 8'h1f);
    u_csl_host_model.rd(8'hbf, rdata);
    `CHK("phase lo", 8'hff, rdata)
    `CHK("shift", 13'h1fff, shift)
    `CHK("delay", 13'h0001, dly)
    u_csl_host_model.wr(8'hbf, 8'h05);
    u_csl_host_model.wr(8'hc0, 8'h00);
    u_csl_host_model.rd(8'hc0, rdata);
    `CHK("phase hi", 8'h00, rdata)
    `CHK("advance", 13'h0005, adv)
    `CHK("no delay", 13'h0000, dly)
    for (int q = 0; q < 8; q++) begin
      u_csl_host_model.wr(8'hc0, {3'(q), 5'h00});
      u_csl_host_model.rd(8'hc0, rdata);
      `CHK("quad byte", {3'(q), 5'h00}, rdata)
      `CHK("quad sel", 3'(q), qsel)
      `CHK("quad step", qs[q], qstep)
    end
    // device reset in mid-run sets the flags again
    @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    `CHK("reset flags", 4'hf, lost)
    `CHK("reset parked", 4'h0, parked)
    u_csl_host_model.rd(8'hb8, rdata);
    `CHK("reset halt", 8'h00, rdata)
    end_sim();
  end
endmodule // csl_clock_ctrl_bench
